/* common/wel_params.svh */
`ifndef WEL_PARAMS_SVH
`define WEL_PARAMS_SVH

// Opcodes of the latch control commands
`define WEL_OP_SET        8'h06
`define WEL_OP_CLEAR      8'h04

// Opcodes that need the latch set beforehand
`define WEL_OP_STATUS_WR  8'h01
`define WEL_OP_ANYREG_WR  8'h71
`define WEL_OP_WRITE      8'h02
`define WEL_OP_FAST_WR    8'hda
`define WEL_OP_DUAL_IN_WR 8'ha2
`define WEL_OP_DUAL_IO_WR 8'ha1
`define WEL_OP_QUAD_IN_WR 8'h32
`define WEL_OP_QUAD_IO_WR 8'hd2
`define WEL_OP_DDR_FAST   8'hdd
`define WEL_OP_DDR_WRITE  8'hde
`define WEL_OP_DDR_QIO_WR 8'hd1
`define WEL_OP_SPECIAL_WR 8'h42
`define WEL_OP_SERIAL_WR  8'hc2

// Frame bit counts
`define WEL_OPCODE_BITS   5'h08
`define WEL_FRAME_BITS    5'h10

// Field position of the latch in status register one
`define WEL_LATCH_POS     1

// Reset values
`define WEL_LATCH_RST     1'b0

// Highest serial clock rate of the latch commands, in MHz
`define WEL_SCLK_MAX_MHZ  108

`endif

/* common/wel_pkg.sv */
package wel_pkg;

	// Command line mode of the serial port
	typedef enum logic [1:0] {
		WEL_MODE_SINGLE = 2'b00,
		WEL_MODE_DUAL   = 2'b01,
		WEL_MODE_QUAD   = 2'b10,
		WEL_MODE_NONE   = 2'b11
	} wel_line_mode_t;

endpackage

/* core/wel_sync.sv */
`timescale 1ns/1ps
module wel_sync #(
	parameter int WIDTH = 6
) (
	input  wire logic             core_clk,
	input  wire logic             rst,
	input  wire logic [WIDTH-1:0] asyncIn,
	output logic      [WIDTH-1:0] syncOut
);

	logic [WIDTH-1:0] meta_q;

	// Two flops per bit
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			meta_q  <= '0;
			syncOut <= '0;
		end else begin
			meta_q  <= asyncIn;
			syncOut <= meta_q;
		end
	end

endmodule // wel_sync

/* core/wel_ctrl.sv */
// Operation
// (RULE1) Opcode 06 hex sets the write latch, bit 1 of status register one.
// (RULE2) Opcode 04 hex clears the write latch.
// (RULE3) Every write-type command runs only while the latch is already one.
// (RULE4) The latch commands carry no address and no dummy cycles, up to 108 MHz clock.
// (RULE5) The latch commands are taken in single, dual and quad command mode at SDR only.
// (RULE6) The host raises chip select right after the eighth opcode bit.
// (RULE7) The latch changes only at chip select rising after a whole 8-bit opcode.
// (RULE8) While a write is in progress the clear command is ignored.
// (RULE9) With the latch clear, every latch-gated write is refused.
// (RULE10) The latch clears at the chip select rise ending a status register write.
// (RULE11) A status register write with the latch clear is ignored.
// (RULE12) A partial opcode at chip select rise is discarded, latch unchanged.
`timescale 1ns/1ps
`include "wel_params.svh"
module wel_ctrl
	import wel_pkg::*;
(
	input  wire logic           core_clk,
	input  wire logic           rst,
	input  wire logic           chipSelN,
	input  wire logic           serialClk,
	input  wire logic [3:0]     ioPin,
	input  wire wel_line_mode_t lineMode,
	input  wire logic           ddrMode,
	input  wire logic           writeInProgressBit,
	output logic                writeLatchBit,
	output logic [7:0]          opcodeByte,
	output logic                opcodeValid,
	output logic                writeGrant,
	output logic                writeRefuse,
	output logic                statusWriteCommit,
	output logic [7:0]          statusWriteData
);

	logic [5:0]  syncBus;
	logic        csN;
	logic        sclk;
	logic [3:0]  ioIn;
	logic        csPrev_q;
	logic        sclkPrev_q;
	logic        csRise;
	logic        sclkRise;
	logic        modeOk;
	logic [4:0]  bitCnt_q;
	logic [4:0]  bitCnt_d;
	logic [15:0] shift_q;
	logic [15:0] shift_d;
	logic        latch_q;
	logic [7:0]  opcode_q;
	logic        opcodeValid_q;
	logic        grant_q;
	logic        refuse_q;
	logic        commit_q;
	logic [7:0]  statusData_q;
	logic        wholeOpcode;

	// Lane count per command mode
	function automatic logic [4:0] laneWidth(input wel_line_mode_t m);
		case (m)
			WEL_MODE_DUAL: laneWidth = 5'h02;
			WEL_MODE_QUAD: laneWidth = 5'h04;
			default:       laneWidth = 5'h01;
		endcase
	endfunction

	// Opcodes that need the latch set
	function automatic logic isGated(input logic [7:0] op);
		case (op)
			`WEL_OP_STATUS_WR, `WEL_OP_ANYREG_WR, `WEL_OP_WRITE, `WEL_OP_FAST_WR,
			`WEL_OP_DUAL_IN_WR, `WEL_OP_DUAL_IO_WR, `WEL_OP_QUAD_IN_WR,
			`WEL_OP_QUAD_IO_WR, `WEL_OP_DDR_FAST, `WEL_OP_DDR_WRITE,
			`WEL_OP_DDR_QIO_WR, `WEL_OP_SPECIAL_WR, `WEL_OP_SERIAL_WR: isGated = 1'b1;
			default: isGated = 1'b0;
		endcase
	endfunction

	wel_sync #(
		.WIDTH (6)
	) u_sync (
		.core_clk (core_clk),
		.rst      (rst),
		.asyncIn  ({ioPin, serialClk, ~chipSelN}),
		.syncOut  (syncBus)
	);

	// Chip select inverted so the cleared synchroniser reads as deselected
	assign csN  = ~syncBus[0];
	assign sclk = syncBus[1];
	assign ioIn = syncBus[5:2];

	// Edge finders on synchronised pins
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			csPrev_q   <= 1'b1;
			sclkPrev_q <= 1'b0;
		end else begin
			csPrev_q   <= csN;
			sclkPrev_q <= sclk;
		end
	end

	assign csRise   = csN & ~csPrev_q;
	assign sclkRise = sclk & ~sclkPrev_q & ~csN;
	assign modeOk   = (lineMode != WEL_MODE_NONE) && !ddrMode; // see (RULE5)

	// Shift in one, two or four bits per rising serial clock, MSB first
	always_comb begin
		bitCnt_d = bitCnt_q;
		shift_d  = shift_q;
		if (sclkRise && bitCnt_q < `WEL_FRAME_BITS) begin
			bitCnt_d = bitCnt_q + laneWidth(lineMode);
			case (lineMode)
				WEL_MODE_DUAL: shift_d = {shift_q[13:0], ioIn[1:0]};
				WEL_MODE_QUAD: shift_d = {shift_q[11:0], ioIn};
				default:       shift_d = {shift_q[14:0], ioIn[0]};
			endcase
		end
	end

	// Frame counter, cleared while deselected
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			bitCnt_q <= 5'h00;
			shift_q  <= 16'h0000;
		end else if (csN) begin
			bitCnt_q <= 5'h00;
			shift_q  <= 16'h0000;
		end else begin
			bitCnt_q <= bitCnt_d;
			shift_q  <= shift_d;
		end
	end

	// Opcode capture and write gating at the eighth bit
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			opcode_q      <= 8'h00;
			opcodeValid_q <= 1'b0;
			grant_q       <= 1'b0;
			refuse_q      <= 1'b0;
		end else begin
			opcodeValid_q <= 1'b0;
			grant_q       <= 1'b0;
			refuse_q      <= 1'b0;
			if (!csN && bitCnt_q != `WEL_OPCODE_BITS && bitCnt_d == `WEL_OPCODE_BITS) begin
				opcode_q      <= shift_d[7:0];
				opcodeValid_q <= 1'b1;
				grant_q       <= isGated(shift_d[7:0]) && latch_q; // see (RULE3)
				refuse_q      <= isGated(shift_d[7:0]) && !latch_q; // see (RULE9)
			end
		end
	end

	// Exactly eight bits, no address or dummy
	assign wholeOpcode = (bitCnt_q == `WEL_OPCODE_BITS); // see (RULE4) see (RULE6) see (RULE12)

	// Latch update only at chip select rise
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			latch_q <= `WEL_LATCH_RST;
		end else if (csRise && bitCnt_q >= `WEL_OPCODE_BITS
			&& opcode_q == `WEL_OP_STATUS_WR) begin
			latch_q <= 1'b0; // see (RULE10)
		end else if (csRise && wholeOpcode && modeOk) begin // see (RULE7)
			if (opcode_q == `WEL_OP_SET) begin
				latch_q <= 1'b1; // see (RULE1)
			end else if (opcode_q == `WEL_OP_CLEAR && !writeInProgressBit) begin // see (RULE8)
				latch_q <= 1'b0; // see (RULE2)
			end
		end
	end

	// Status register write commits only with the latch set
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			commit_q     <= 1'b0;
			statusData_q <= 8'h00;
		end else begin
			commit_q <= 1'b0;
			if (csRise && bitCnt_q == `WEL_FRAME_BITS
				&& opcode_q == `WEL_OP_STATUS_WR && latch_q) begin // see (RULE11)
				commit_q     <= 1'b1;
				statusData_q <= shift_q[7:0];
			end
		end
	end

	assign writeLatchBit     = latch_q;
	assign opcodeByte        = opcode_q;
	assign opcodeValid       = opcodeValid_q;
	assign writeGrant        = grant_q;
	assign writeRefuse       = refuse_q;
	assign statusWriteCommit = commit_q;
	assign statusWriteData   = statusData_q;

	set_latch_a: assert property (@(posedge core_clk) disable iff (rst) // see (RULE1)
		csRise && wholeOpcode && modeOk && opcode_q == `WEL_OP_SET |=> latch_q)
		else $error("set opcode did not set latch");

	clear_latch_a: assert property (@(posedge core_clk) disable iff (rst) // see (RULE2)
		csRise && wholeOpcode && modeOk && opcode_q == `WEL_OP_CLEAR
		&& !writeInProgressBit |=> !latch_q)
		else $error("clear opcode did not clear latch");

	grant_gate_a: assert property (@(posedge core_clk) disable iff (rst) // see (RULE3)
		grant_q |-> $past(latch_q) && isGated(opcode_q))
		else $error("write granted without latch");

	mode_refuse_a: assert property (@(posedge core_clk) disable iff (rst) // see (RULE5)
		csRise && !modeOk && opcode_q != `WEL_OP_STATUS_WR |=> $stable(latch_q))
		else $error("latch changed in refused mode");

	csrise_only_a: assert property (@(posedge core_clk) disable iff (rst) // see (RULE7)
		!csRise |=> $stable(latch_q))
		else $error("latch changed away from chip select rise");

	wip_hold_a: assert property (@(posedge core_clk) disable iff (rst) // see (RULE8)
		csRise && opcode_q == `WEL_OP_CLEAR && writeInProgressBit |=> $stable(latch_q))
		else $error("clear taken during write in progress");

	refuse_gate_a: assert property (@(posedge core_clk) disable iff (rst) // see (RULE9)
		opcodeValid_q && isGated(opcode_q) && !$past(latch_q) |-> refuse_q && !grant_q)
		else $error("gated write not refused");

	status_clear_a: assert property (@(posedge core_clk) disable iff (rst) // see (RULE10)
		csRise && bitCnt_q >= `WEL_OPCODE_BITS && opcode_q == `WEL_OP_STATUS_WR |=> !latch_q)
		else $error("latch kept after status write");

	status_ignore_a: assert property (@(posedge core_clk) disable iff (rst) // see (RULE11)
		commit_q |-> $past(latch_q) && !latch_q)
		else $error("status write committed without latch");

	partial_keep_a: assert property (@(posedge core_clk) disable iff (rst) // see (RULE12)
		csRise && bitCnt_q < `WEL_OPCODE_BITS |=> $stable(latch_q))
		else $error("partial opcode changed latch");

endmodule // wel_ctrl

/* dv/wel_host_model.sv */
`timescale 1ns/1ps
module wel_host_model
	import wel_pkg::*;
(
	input  wire logic core_clk,
	output logic      chipSelN,
	output logic      serialClk,
	output logic [3:0] ioPin
);
	initial begin
		chipSelN = 1'b1;
		serialClk = 1'b0;
		ioPin = 4'h5;
	end
	// One frame, MSB first, clock still outside it
	task automatic frame(input logic [15:0] bits, input int nBits, input wel_line_mode_t m);
		int w;
		logic [3:0] v;
		w = (m == WEL_MODE_QUAD) ? 4 : (m == WEL_MODE_DUAL) ? 2 : 1;
		@(posedge core_clk);
		#1 chipSelN = 1'b0;
		for (int k = 0; k < nBits; k += w) begin
			v = ~ioPin;
			for (int b = 0; b < w; b++)
				v[b] = bits[15 - k - (w - 1 - b)];
			ioPin = v;
			repeat (10) @(posedge core_clk);
			#1 serialClk = 1'b1;
			repeat (10) @(posedge core_clk);
			#1 serialClk = 1'b0;
		end
		chipSelN = 1'b1;
		ioPin = ~ioPin;
		repeat (8) @(posedge core_clk);
	endtask
endmodule // wel_host_model

/* dv/wel_ctrl_tb.sv */
`timescale 1ns/1ps
`include "wel_params.svh"
module wel_ctrl_tb
	import wel_pkg::*;
;
	logic           core_clk = 1'b0;
	logic           rst = 1'b1;
	logic           chipSelN, serialClk;
	logic [3:0]     ioPin;
	wel_line_mode_t lineMode = WEL_MODE_SINGLE;
	logic           ddrMode = 1'b0;
	logic           writeInProgressBit = 1'b0;
	logic           writeLatchBit, opcodeValid, writeGrant, writeRefuse, statusWriteCommit;
	logic [7:0]     opcodeByte, statusWriteData;
	logic           expLatch = 1'b0;
	int             nOp = 0, nGrant = 0, nRefuse = 0, nCommit = 0;
	int             n_fail = 0, n_tests = 0;
	logic [7:0]     gatedOps [13] = '{`WEL_OP_STATUS_WR, `WEL_OP_ANYREG_WR, `WEL_OP_WRITE,
		`WEL_OP_FAST_WR, `WEL_OP_DUAL_IN_WR, `WEL_OP_DUAL_IO_WR, `WEL_OP_QUAD_IN_WR,
		`WEL_OP_QUAD_IO_WR, `WEL_OP_DDR_FAST, `WEL_OP_DDR_WRITE, `WEL_OP_DDR_QIO_WR,
		`WEL_OP_SPECIAL_WR, `WEL_OP_SERIAL_WR};

	always #4 core_clk = ~core_clk;

	always @(posedge core_clk) begin
		nOp += (opcodeValid === 1'b1);
		nGrant += (writeGrant === 1'b1);
		nRefuse += (writeRefuse === 1'b1);
		nCommit += (statusWriteCommit === 1'b1);
	end

	wel_host_model wel_host_model_i (.core_clk(core_clk), .chipSelN(chipSelN),
		.serialClk(serialClk), .ioPin(ioPin));

	wel_ctrl wel_ctrl_i (.core_clk(core_clk), .rst(rst), .chipSelN(chipSelN),
		.serialClk(serialClk), .ioPin(ioPin), .lineMode(lineMode), .ddrMode(ddrMode),
		.writeInProgressBit(writeInProgressBit), .writeLatchBit(writeLatchBit),
		.opcodeByte(opcodeByte), .opcodeValid(opcodeValid), .writeGrant(writeGrant),
		.writeRefuse(writeRefuse), .statusWriteCommit(statusWriteCommit),
		.statusWriteData(statusWriteData));

	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_fail++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic tally_and_finish();
		$display("Checks %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// One frame through the host, then compare with the reference model
	task automatic run(input logic [7:0] op, input logic [7:0] dat, input int n,
		input wel_line_mode_t m, input logic ddr, input logic write_in_progress_bit);
		int o0, g0, r0, c0;
		logic ok, gated, expCommit;
		ok = (m != WEL_MODE_NONE) && !ddr && n == 8;
		gated = (op inside {gatedOps}) && n >= 8;
		expCommit = (op == `WEL_OP_STATUS_WR) && n == 16 && expLatch;
		o0 = nOp;
		g0 = nGrant;
		r0 = nRefuse;
		c0 = nCommit;
		@(posedge core_clk);
		#1 lineMode = m;
		ddrMode = ddr;
		writeInProgressBit = write_in_progress_bit;
		wel_host_model_i.frame({op, dat}, n, m);
		check("grant", 8'(nGrant - g0), 8'(gated && expLatch));
		check("refuse", 8'(nRefuse - r0), 8'(gated && !expLatch));
		check("commit", 8'(nCommit - c0), 8'(expCommit));
		if (expCommit)
			check("status data", statusWriteData, dat);
		if (m != WEL_MODE_NONE)
			check("opcode count", 8'(nOp - o0), 8'(n >= 8));
		if (m != WEL_MODE_NONE && n >= 8)
			check("opcode", opcodeByte, op);
		if (op == `WEL_OP_SET && ok)
			expLatch = 1'b1;
		if (op == `WEL_OP_CLEAR && ok && !write_in_progress_bit)
			expLatch = 1'b0;
		if (op == `WEL_OP_STATUS_WR && n >= 8)
			expLatch = 1'b0;
		check("latch", {7'h0, writeLatchBit}, {7'h0, expLatch});
	endtask

	initial begin
		void'($urandom(98945));
		repeat (8) @(posedge core_clk);
		#1 rst = 1'b0;
		repeat (4) @(posedge core_clk);
		foreach (gatedOps[i]) begin
			run(gatedOps[i], 8'h00, 8, WEL_MODE_SINGLE, 1'b0, 1'b0);
			run(`WEL_OP_SET, 8'h00, 8, wel_line_mode_t'(2'(i % 3)), 1'b0, 1'b0);
			run(gatedOps[i], 8'($urandom), 16, WEL_MODE_SINGLE, 1'b0, 1'b0);
			run(`WEL_OP_SET, 8'h00, 8, WEL_MODE_SINGLE, 1'b0, 1'b0);
			run(`WEL_OP_CLEAR, 8'h00, 8, wel_line_mode_t'(2'(i % 3)), 1'b0, 1'($urandom));
		end
		$display("Test gated writes and latch modes done");
		run(`WEL_OP_SET, 8'h00, 8, WEL_MODE_DUAL, 1'b0, 1'b0);
		run(`WEL_OP_CLEAR, 8'h00, 1 + $urandom % 7, WEL_MODE_SINGLE, 1'b0, 1'b0);
		run(`WEL_OP_CLEAR, 8'hff, 9, WEL_MODE_SINGLE, 1'b0, 1'b0);
		run(`WEL_OP_CLEAR, 8'h00, 8, WEL_MODE_NONE, 1'b0, 1'b0);
		run(`WEL_OP_CLEAR, 8'h00, 8, WEL_MODE_SINGLE, 1'b1, 1'b0);
		run(`WEL_OP_CLEAR, 8'h00, 8, WEL_MODE_QUAD, 1'b0, 1'b0);
		run(`WEL_OP_SET, 8'h00, 8, WEL_MODE_QUAD, 1'b1, 1'b0);
		run(`WEL_OP_SET, 8'h00, 4, WEL_MODE_SINGLE, 1'b0, 1'b0);
		run(`WEL_OP_STATUS_WR, 8'($urandom), 16, WEL_MODE_SINGLE, 1'b0, 1'b0);
		$display("Test refused frames done");
		tally_and_finish();
	end

	initial begin
		repeat (100000) @(posedge core_clk);
		n_fail++;
		$display("BAD run time expected end seen hang");
		tally_and_finish();
	end
endmodule // wel_ctrl_tb
